// ==== core/reset_and_simd_exception_unit.sv ====
// reset entry, reset cause status and simd exceptions of the core
// Operation
// - reset taken on system pin, power-on pin, watchdog or debug control
// - reset branches to vector from base pins, 20-bit or 30-bit form
// - reset aborts every operation in flight; machine state is lost
// - watchdog or debug control drives the active-low reset request out
// - watchdog cause field: none, checkstop, reset out, reserved
// - last-reset field reads 01 after a reset until software clears it
// - reset clears the syndrome, leaves critical saves and fault address
// - simd unavailable when simd enable clear and non-exempt simd op
// - unavailable simd op is suppressed, nothing commits
// - unavailable saves the op address in save_pc
// - both simd traps copy old state to save_state, others untouched
// - both simd traps syndrome: simd bit, varlen flag, rest cleared
// - unavailable vector is prefix high half, offset 12 bits, zeros
// - fp data trap taken when raised and nothing higher pending
// - fp data trap suppresses the op and saves its address
// - fp data vector is prefix high half, offset 12 bits, zeros
// - reset outranks every exception and is taken at once
//
// The register addresses and the Wishbone register port were chosen for this implementation.
module reset_and_simd_exception_unit
	import exc_unit_pkg::*;
#(
	parameter logic RST_BASE_WIDE = 1'b0,
	parameter int RSTOUT_CYCLES = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [ADR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_sys_rst_n,
	input wire logic i_por,
	input wire logic [29:0] i_rst_base,
	input wire logic i_wdog_rst,
	input wire logic i_wdog_chkstop,
	input wire logic i_dbg_rst,
	input wire logic i_instr_valid,
	input wire logic [31:0] i_instr_ea,
	input wire logic i_instr_simd,
	input wire logic i_instr_simd_exempt,
	input wire logic i_instr_varlen,
	input wire logic i_fpdata_exc,
	input wire logic i_higher_pend,
	output logic o_commit,
	output logic o_suppress,
	output logic o_redirect,
	output logic [31:0] o_redirect_pc,
	output logic o_abort,
	output logic o_rst_req_n,
	output logic o_in_reset
);

	localparam int CNT_W = $clog2(RSTOUT_CYCLES + 1);
	localparam logic [CNT_W-1:0] RSTOUT_LOAD = CNT_W'(RSTOUT_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0, CNT_ONE = CNT_W'(1);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [31:0] pins_sync;
	logic sys_rst_s, por_s;
	logic [29:0] base_s;

	// system reset inverted ahead of the flops so all bits reset to idle
	exc_sync2 #(.WIDTH(32)) u_pin_sync (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_async({i_rst_base, i_por, ~i_sys_rst_n}),
		.o_sync(pins_sync)
	);

	assign {base_s, por_s, sys_rst_s} = pins_sync;

	// ---------------------------------------------------------------
	// state and registers
	// ---------------------------------------------------------------
	exc_state_t state_r, state_nxt;
	logic [31:0] machine_state_r, save_pc_r, save_state_r;
	logic [31:0] crit_save_pc_r, crit_save_state_r, exc_syndrome_r;
	logic [31:0] data_exc_addr_r, mcheck_syndrome_r, vector_prefix_r;
	logic [31:0] vec_off_simd_unavail_r, vec_off_simd_fpdata_r;
	logic [1:0] watchdog_rst_cause_r, last_rst_flag_r;
	logic [CNT_W-1:0] rstout_cnt_r, rstout_cnt_nxt;
	logic [31:0] wb_dat_r, redirect_pc_r;
	logic wb_ack_r, commit_r, suppress_r, redirect_r, abort_r;
	logic rst_req_n_r, in_reset_r;

	logic rst_any, rst_ctl, run_slot, unavail_cond;
	logic take_unavail, take_fpdata, take_exc, wb_wr;
	logic [31:0] rst_vector, exc_vector, rd_data;

	// ---------------------------------------------------------------
	// cause decode
	// ---------------------------------------------------------------
	// reset needs no recoverable point, so it is not qualified by state
	assign rst_ctl = i_wdog_rst | i_dbg_rst;
	assign rst_any = sys_rst_s | por_s | rst_ctl;
	assign run_slot = (state_r == ST_RUN) & ~rst_any;
	assign unavail_cond = i_instr_simd & ~i_instr_simd_exempt
		& ~machine_state_r[MSR_SIMD];
	assign take_unavail = run_slot & i_instr_valid & unavail_cond;
	assign take_fpdata = run_slot & i_instr_valid & ~unavail_cond
		& i_fpdata_exc & ~i_higher_pend;
	assign take_exc = take_unavail | take_fpdata;

	// only the top bits of the base pins count in the narrow form
	assign rst_vector = RST_BASE_WIDE ? {base_s, RST_TAIL_WIDE}
		: {base_s[29:10], RST_TAIL_NARROW};
	assign exc_vector = take_unavail
		? ivec(vector_prefix_r, vec_off_simd_unavail_r)
		: ivec(vector_prefix_r, vec_off_simd_fpdata_r);

	// ---------------------------------------------------------------
	// reset sequencer
	// ---------------------------------------------------------------
	// stay in reset while any source holds, then issue the vector once
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				state_nxt = rst_any ? ST_RESET : ST_RUN;
			end
			ST_RESET: begin
				state_nxt = rst_any ? ST_RESET : ST_VECTOR;
			end
			ST_VECTOR: begin
				state_nxt = rst_any ? ST_RESET : ST_RUN;
			end
			default: state_nxt = ST_RESET;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ---------------------------------------------------------------
	// pipeline control outputs
	// ---------------------------------------------------------------
	// an op blocked only by a higher pending fault neither commits
	// nor is suppressed here; the unit that owns that fault decides
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			commit_r <= 1'b0;
			suppress_r <= 1'b0;
			abort_r <= 1'b0;
			in_reset_r <= 1'b0;
		end else begin
			commit_r <= run_slot & i_instr_valid & ~unavail_cond
				& ~i_fpdata_exc;
			suppress_r <= take_exc;
			abort_r <= rst_any;
			in_reset_r <= (state_nxt == ST_RESET);
		end
	end

	// redirect pulse carries either the reset or the trap vector
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			redirect_r <= 1'b0;
			redirect_pc_r <= 32'h0000_0000;
		end else if (state_r == ST_RESET && !rst_any) begin
			redirect_r <= 1'b1;
			redirect_pc_r <= rst_vector;
		end else if (take_exc) begin
			redirect_r <= 1'b1;
			redirect_pc_r <= exc_vector;
		end else begin
			redirect_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// reset request out
	// ---------------------------------------------------------------
	// stretched so a one-cycle control pulse is seen by slow board logic
	always_comb begin
		rstout_cnt_nxt = rstout_cnt_r;
		if (rst_ctl) begin
			rstout_cnt_nxt = RSTOUT_LOAD;
		end else if (rstout_cnt_r != CNT_ZERO) begin
			rstout_cnt_nxt = rstout_cnt_r - CNT_ONE;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			rstout_cnt_r <= '0;
			rst_req_n_r <= 1'b1;
		end else begin
			rstout_cnt_r <= rstout_cnt_nxt;
			rst_req_n_r <= (rstout_cnt_nxt == CNT_ZERO);
		end
	end

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	// write lands on the edge where ack is high, as the master samples
	assign wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & wb_ack_r;

	// unmapped offsets read zero and ignore writes, but still ack
	always_comb begin
		rd_data = 32'h0000_0000;
		case (i_wb_adr)
			ADR_MACHINE_STATE: rd_data = machine_state_r;
			ADR_SAVE_PC: rd_data = save_pc_r;
			ADR_SAVE_STATE: rd_data = save_state_r;
			ADR_CRIT_SAVE_PC: rd_data = crit_save_pc_r;
			ADR_CRIT_SAVE_STATE: rd_data = crit_save_state_r;
			ADR_EXC_SYNDROME: rd_data = exc_syndrome_r;
			ADR_DATA_EXC_ADDR: rd_data = data_exc_addr_r;
			ADR_MCHECK_SYNDROME: rd_data = mcheck_syndrome_r;
			ADR_VECTOR_PREFIX: rd_data = vector_prefix_r;
			ADR_VEC_OFF_SIMD_UNAVAIL: rd_data = vec_off_simd_unavail_r;
			ADR_VEC_OFF_SIMD_FPDATA: rd_data = vec_off_simd_fpdata_r;
			ADR_TIMER_STATUS: rd_data[STAT_HI:STAT_LO] = watchdog_rst_cause_r;
			ADR_DEBUG_STATUS: rd_data[STAT_HI:STAT_LO] = last_rst_flag_r;
			ADR_RST_VECTOR: rd_data = rst_vector;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			wb_ack_r <= 1'b0;
			wb_dat_r <= 32'h0000_0000;
		end else begin
			wb_ack_r <= i_wb_cyc & i_wb_stb & ~wb_ack_r;
			if (i_wb_cyc && i_wb_stb && !wb_ack_r) begin
				wb_dat_r <= rd_data;
			end
		end
	end

	// ---------------------------------------------------------------
	// state and save registers
	// ---------------------------------------------------------------
	// hardware entry wins over a software write in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn || rst_any) begin
			machine_state_r <= MSR_RST_VAL;
		end else if (take_exc) begin
			machine_state_r <= machine_state_r & ~MSR_SIMD_CLR;
		end else if (wb_wr && i_wb_adr == ADR_MACHINE_STATE) begin
			machine_state_r <= wb_merge(machine_state_r, i_wb_dat, i_wb_sel);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			save_pc_r <= 32'h0000_0000;
			save_state_r <= 32'h0000_0000;
		end else if (take_exc) begin
			save_pc_r <= i_instr_ea;
			save_state_r <= machine_state_r;
		end else if (wb_wr) begin
			if (i_wb_adr == ADR_SAVE_PC) begin
				save_pc_r <= wb_merge(save_pc_r, i_wb_dat, i_wb_sel);
			end
			if (i_wb_adr == ADR_SAVE_STATE) begin
				save_state_r <= wb_merge(save_state_r, i_wb_dat, i_wb_sel);
			end
		end
	end

	// syndrome: cleared by reset, rebuilt whole by a simd trap
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn || rst_any) begin
			exc_syndrome_r <= ESR_RST_VAL;
		end else if (take_exc) begin
			exc_syndrome_r <= ESR_RST_VAL;
			exc_syndrome_r[ESR_SIMD] <= 1'b1;
			exc_syndrome_r[ESR_VARLEN] <= i_instr_varlen;
		end else if (wb_wr && i_wb_adr == ADR_EXC_SYNDROME) begin
			exc_syndrome_r <= wb_merge(exc_syndrome_r, i_wb_dat, i_wb_sel);
		end
	end

	// neither reset nor the simd traps touch these; software owns them
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			crit_save_pc_r <= 32'h0000_0000;
			crit_save_state_r <= 32'h0000_0000;
			data_exc_addr_r <= 32'h0000_0000;
			mcheck_syndrome_r <= 32'h0000_0000;
			vector_prefix_r <= 32'h0000_0000;
			vec_off_simd_unavail_r <= 32'h0000_0000;
			vec_off_simd_fpdata_r <= 32'h0000_0000;
		end else if (wb_wr) begin
			case (i_wb_adr)
				ADR_CRIT_SAVE_PC: crit_save_pc_r <=
					wb_merge(crit_save_pc_r, i_wb_dat, i_wb_sel);
				ADR_CRIT_SAVE_STATE: crit_save_state_r <=
					wb_merge(crit_save_state_r, i_wb_dat, i_wb_sel);
				ADR_DATA_EXC_ADDR: data_exc_addr_r <=
					wb_merge(data_exc_addr_r, i_wb_dat, i_wb_sel);
				ADR_MCHECK_SYNDROME: mcheck_syndrome_r <=
					wb_merge(mcheck_syndrome_r, i_wb_dat, i_wb_sel);
				ADR_VECTOR_PREFIX: vector_prefix_r <=
					wb_merge(vector_prefix_r, i_wb_dat, i_wb_sel);
				ADR_VEC_OFF_SIMD_UNAVAIL: vec_off_simd_unavail_r <=
					wb_merge(vec_off_simd_unavail_r, i_wb_dat, i_wb_sel);
				ADR_VEC_OFF_SIMD_FPDATA: vec_off_simd_fpdata_r <=
					wb_merge(vec_off_simd_fpdata_r, i_wb_dat, i_wb_sel);
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// reset cause status
	// ---------------------------------------------------------------
	// write one to clear; a cause in the same cycle wins over the clear
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			watchdog_rst_cause_r <= WRS_NONE;
		end else if (i_wdog_rst) begin
			watchdog_rst_cause_r <= WRS_RSTOUT;
		end else if (i_wdog_chkstop) begin
			watchdog_rst_cause_r <= WRS_CHKSTOP;
		end else if (wb_wr && i_wb_adr == ADR_TIMER_STATUS
			&& i_wb_sel[STAT_BYTE]) begin
			watchdog_rst_cause_r <= watchdog_rst_cause_r
				& ~i_wb_dat[STAT_HI:STAT_LO];
		end
	end

	// only code 01 is ever set, so the reserved codes never appear
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			last_rst_flag_r <= LRST_NONE;
		end else if (rst_any) begin
			last_rst_flag_r <= LRST_SEEN;
		end else if (wb_wr && i_wb_adr == ADR_DEBUG_STATUS
			&& i_wb_sel[STAT_BYTE]) begin
			last_rst_flag_r <= last_rst_flag_r & ~i_wb_dat[STAT_HI:STAT_LO];
		end
	end

	// ---------------------------------------------------------------
	// output wiring, all from flops
	// ---------------------------------------------------------------
	assign o_wb_dat = wb_dat_r;
	assign o_wb_ack = wb_ack_r;
	assign o_commit = commit_r;
	assign o_suppress = suppress_r;
	assign o_redirect = redirect_r;
	assign o_redirect_pc = redirect_pc_r;
	assign o_abort = abort_r;
	assign o_rst_req_n = rst_req_n_r;
	assign o_in_reset = in_reset_r;

endmodule

// ==== core/exc_unit_pkg.sv ====
// constants, register map and helpers of the reset and simd exception unit
package exc_unit_pkg;

	// ---------------------------------------------------------------
	// register map, byte offsets on the bus
	// ---------------------------------------------------------------
	localparam int unsigned ADR_W = 8;
	localparam logic [7:0] ADR_MACHINE_STATE = 8'h00;
	localparam logic [7:0] ADR_SAVE_PC = 8'h04;
	localparam logic [7:0] ADR_SAVE_STATE = 8'h08;
	localparam logic [7:0] ADR_CRIT_SAVE_PC = 8'h0C;
	localparam logic [7:0] ADR_CRIT_SAVE_STATE = 8'h10;
	localparam logic [7:0] ADR_EXC_SYNDROME = 8'h14;
	localparam logic [7:0] ADR_DATA_EXC_ADDR = 8'h18;
	localparam logic [7:0] ADR_MCHECK_SYNDROME = 8'h1C;
	localparam logic [7:0] ADR_VECTOR_PREFIX = 8'h20;
	localparam logic [7:0] ADR_VEC_OFF_SIMD_UNAVAIL = 8'h24;
	localparam logic [7:0] ADR_VEC_OFF_SIMD_FPDATA = 8'h28;
	localparam logic [7:0] ADR_TIMER_STATUS = 8'h2C;
	localparam logic [7:0] ADR_DEBUG_STATUS = 8'h30;
	localparam logic [7:0] ADR_RST_VECTOR = 8'h34;

	// ---------------------------------------------------------------
	// machine_state bit positions (bit 0 is the lsb)
	// ---------------------------------------------------------------
	localparam int MSR_USER_CACHE_LOCK_EN = 26;
	localparam int MSR_SIMD = 25;
	localparam int MSR_WE = 18;
	localparam int MSR_CE = 17;
	localparam int MSR_EE = 15;
	localparam int MSR_PR = 14;
	localparam int MSR_FP = 13;
	localparam int MSR_ME = 12;
	localparam int MSR_FE0 = 11;
	localparam int MSR_DE = 9;
	localparam int MSR_FE1 = 8;
	localparam int MSR_IS = 5;
	localparam int MSR_DS = 4;
	localparam int MSR_RI = 1;
	localparam logic [31:0] MSR_RST_VAL = 32'h0000_0000;
	// bits cleared on entry to either simd handler; ce, me, de, ri stay
	localparam logic [31:0] MSR_SIMD_CLR = (32'h1 << MSR_USER_CACHE_LOCK_EN)
		| (32'h1 << MSR_SIMD) | (32'h1 << MSR_WE) | (32'h1 << MSR_EE)
		| (32'h1 << MSR_PR) | (32'h1 << MSR_FP) | (32'h1 << MSR_FE0)
		| (32'h1 << MSR_FE1) | (32'h1 << MSR_IS) | (32'h1 << MSR_DS);

	// ---------------------------------------------------------------
	// exc_syndrome bits and status fields
	// ---------------------------------------------------------------
	localparam int ESR_SIMD = 7;
	localparam int ESR_VARLEN = 5;
	localparam logic [31:0] ESR_RST_VAL = 32'h0000_0000;
	localparam int STAT_HI = 29;
	localparam int STAT_LO = 28;
	localparam int STAT_BYTE = 3;
	localparam logic [1:0] WRS_NONE = 2'h0;
	localparam logic [1:0] WRS_CHKSTOP = 2'h1;
	localparam logic [1:0] WRS_RSTOUT = 2'h2;
	localparam logic [1:0] LRST_NONE = 2'h0;
	localparam logic [1:0] LRST_SEEN = 2'h1;

	// ---------------------------------------------------------------
	// vector tails
	// ---------------------------------------------------------------
	localparam logic [11:0] RST_TAIL_NARROW = 12'hFFC;
	localparam logic [1:0] RST_TAIL_WIDE = 2'h0;
	localparam logic [3:0] IVEC_TAIL = 4'h0;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_RESET,
		ST_VECTOR
	} exc_state_t;

	// byte-lane merge of a bus write into an old value
	function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// prefix high half, offset bits, four zero bits
	function automatic logic [31:0] ivec(input logic [31:0] prefix,
		input logic [31:0] offs);
		return {prefix[31:16], offs[15:4], IVEC_TAIL};
	endfunction

endpackage

// ==== core/exc_sync2.sv ====
// two flip-flop synchroniser for a bundle of pin levels
module exc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// first stage feeds only the second; each bit crosses on its own
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule

// ==== test/exc_unit_checker.sv ====
// port checks of the reset and simd exception unit
module exc_unit_checker
	import exc_unit_pkg::*;
#(
	parameter logic RST_BASE_WIDE = 1'h0,
	parameter int RSTOUT_CYCLES = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [29:0] i_rst_base,
	input wire logic i_wdog_rst,
	input wire logic i_dbg_rst,
	input wire logic i_instr_valid,
	input wire logic i_instr_simd,
	input wire logic i_instr_simd_exempt,
	input wire logic i_fpdata_exc,
	input wire logic i_higher_pend,
	input wire logic o_commit,
	input wire logic o_suppress,
	input wire logic o_redirect,
	input wire logic [31:0] o_redirect_pc,
	input wire logic o_abort,
	input wire logic o_rst_req_n,
	input wire logic o_in_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RQ_MAX = RSTOUT_CYCLES + 2;
	logic quiet;
	logic fp_op;
	logic [31:0] rvec;
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// instructions judged only far from any reset, traps aside
	assign quiet = !o_abort && !o_in_reset && !o_redirect
		&& !i_dbg_rst && !i_wdog_rst;
	assign fp_op = quiet && i_instr_valid && i_instr_simd
		&& i_instr_simd_exempt && i_fpdata_exc;
	// strap held constant, so the raw pins give the vector
	assign rvec = RST_BASE_WIDE ? {i_rst_base, RST_TAIL_WIDE}
		: {i_rst_base[29:10], RST_TAIL_NARROW};
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);
	AST_RST_ENTRY: assert property (
		(i_dbg_rst || i_wdog_rst) |=> o_abort && o_in_reset
		&& !o_commit && !o_suppress)
		else $error("reset control not taken at once");
	AST_REQ_OUT: assert property (
		(i_dbg_rst || i_wdog_rst) |=> !o_rst_req_n)
		else $error("reset request not driven low");
	AST_REQ_LEN: assert property (
		$fell(i_wdog_rst || i_dbg_rst) |-> !o_rst_req_n
		##[1:RQ_MAX] o_rst_req_n)
		else $error("reset request length wrong");
	AST_RST_VEC: assert property (
		$fell(o_in_reset) |-> o_redirect && o_redirect_pc == rvec)
		else $error("reset vector wrong");
	AST_ABORT_HALT: assert property (
		o_abort |-> !o_commit && !o_suppress)
		else $error("work finished during abort");
	AST_SUP_PAIR: assert property (
		o_suppress |-> o_redirect && !o_commit)
		else $error("suppressed op committed or not redirected");
	AST_FP_BLOCK: assert property (
		fp_op && i_higher_pend |=> !o_commit && !o_suppress)
		else $error("fp data trap taken over higher fault");
	AST_FP_TAKE: assert property (
		fp_op && !i_higher_pend |=> o_suppress && o_redirect)
		else $error("fp data trap missing");
	AST_PLAIN: assert property (
		quiet && i_instr_valid && !i_instr_simd && !i_fpdata_exc
		|=> o_commit && !o_suppress)
		else $error("plain op did not commit");
endmodule

// ==== test/rst_strap_model.sv ====
// system reset pins and base strap seen from outside the core
module rst_strap_model #(
	parameter int HOLD = 6,
	parameter logic [29:0] BASE = 30'h0000_0000
) (
	input wire logic i_core_clk,
	input wire logic i_rst_req_n,
	input wire logic i_fold_en,
	input wire logic i_pin_go,
	input wire logic i_por_go,
	output logic o_sys_rst_n,
	output logic o_por,
	output logic [29:0] o_rst_base
);
	timeunit 1ns;
	timeprecision 1ps;
	int pin_cnt = 0;
	int por_cnt = HOLD;
	// stretch every request so the core sees a full reset interval
	always @(posedge i_core_clk) begin
		pin_cnt <= i_pin_go ? HOLD : (pin_cnt > 0 ? pin_cnt - 1 : 0);
		por_cnt <= i_por_go ? HOLD : (por_cnt > 0 ? por_cnt - 1 : 0);
	end
	// request out folded into the system pin when enabled
	assign o_sys_rst_n = pin_cnt == 0 && (i_rst_req_n || !i_fold_en);
	assign o_por = por_cnt != 0;
	assign o_rst_base = BASE;
endmodule

// ==== test/reset_and_simd_exception_unit_bench.sv ====
// bench of the reset and simd exception unit
module reset_and_simd_exception_unit_bench import exc_unit_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [29:0] BASE = 30'h2AB5_1C3;
	localparam logic [31:0] RVEC = {BASE[29:10], 12'hFFC};
	logic clk = '0, rstn = '0, cyc = '0, stb = '0, we = '0, ack;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat, ea = '0, rpc, q, m0;
	logic dbg = '0, wrst = '0, wchk = '0, iv = '0, simd = '0, exm = '0;
	logic vl = '0, fpx = '0, hp = '0, fold = '0, pin_go = '0, por_go = '0;
	logic sys_n, por, commit, sup, redir, abort, rreq_n, in_rst;
	logic [29:0] base;
	int fail_count = 0, samples_checked = 0;
	always #5 clk = ~clk;
	reset_and_simd_exception_unit #(.RSTOUT_CYCLES(4)) dut (
		.i_core_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_sys_rst_n(sys_n), .i_por(por),
		.i_rst_base(base), .i_wdog_rst(wrst), .i_wdog_chkstop(wchk),
		.i_dbg_rst(dbg), .i_instr_valid(iv), .i_instr_ea(ea),
		.i_instr_simd(simd), .i_instr_simd_exempt(exm), .i_instr_varlen(vl),
		.i_fpdata_exc(fpx), .i_higher_pend(hp), .o_commit(commit),
		.o_suppress(sup), .o_redirect(redir), .o_redirect_pc(rpc),
		.o_abort(abort), .o_rst_req_n(rreq_n), .o_in_reset(in_rst));
	rst_strap_model #(.BASE(BASE)) far (.i_core_clk(clk),
		.i_rst_req_n(rreq_n), .i_fold_en(fold), .i_pin_go(pin_go),
		.i_por_go(por_go), .o_sys_rst_n(sys_n), .o_por(por),
		.o_rst_base(base));
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// a wait that ran out ends the run as a mismatch
	task automatic guard(input int n);
		if (n >= 60) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 60);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		guard(n);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'h1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		chk(q, e);
	endtask
	// one op at the commit point; e is {commit, suppress}
	task automatic op(input logic s, x, f, h, v, input logic [31:0] a,
		input logic [1:0] e);
		@(posedge clk);
		iv <= 1'h1;
		simd <= s;
		exm <= x;
		fpx <= f;
		hp <= h;
		vl <= v;
		ea <= a;
		@(posedge clk);
		iv <= 1'h0;
		fpx <= 1'h0;
		@(posedge clk);
		chk({commit, sup}, e);
	endtask
	task automatic wait_rst(input logic want);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (in_rst !== want && n < 60);
		guard(n);
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		rd(ADR_MACHINE_STATE, MSR_RST_VAL);
		rd(ADR_TIMER_STATUS, 32'h0);
		rd(ADR_DEBUG_STATUS, 32'h0);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, 32'h0);
		wr(ADR_RST_VECTOR, 32'h0);
		rd(ADR_RST_VECTOR, RVEC);
		wr(ADR_VECTOR_PREFIX, 32'hABCD_0000);
		wr(ADR_VEC_OFF_SIMD_UNAVAIL, 32'h0000_1230);
		wr(ADR_VEC_OFF_SIMD_FPDATA, 32'h0000_4560);
		wr(ADR_DATA_EXC_ADDR, 32'h1357_9BDF);
		wr(ADR_MCHECK_SYNDROME, 32'h0000_0F0F);
	endtask
	task automatic t_unavail();
		logic [31:0] mc, de;
		wr(ADR_MACHINE_STATE, 32'hFDFF_FFFF);
		wb(1'h0, ADR_MACHINE_STATE, 32'h0);
		m0 = q;
		wb(1'h0, ADR_MCHECK_SYNDROME, 32'h0);
		mc = q;
		wb(1'h0, ADR_DATA_EXC_ADDR, 32'h0);
		de = q;
		wr(ADR_EXC_SYNDROME, 32'h0000_FF00);
		op(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 32'h0000_8A40, 2'h1);
		chk(rpc, 32'hABCD_1230);
		rd(ADR_SAVE_PC, 32'h0000_8A40);
		rd(ADR_SAVE_STATE, m0);
		rd(ADR_EXC_SYNDROME, 32'h0000_00A0);
		rd(ADR_MACHINE_STATE, m0 & ~MSR_SIMD_CLR);
		rd(ADR_MCHECK_SYNDROME, mc);
		rd(ADR_DATA_EXC_ADDR, de);
	endtask
	task automatic t_commit();
		op(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0000_0100, 2'h2);
		op(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 32'h0000_0104, 2'h2);
		wr(ADR_MACHINE_STATE, 32'h0200_0000);
		op(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0000_0108, 2'h2);
		wr(ADR_MACHINE_STATE, 32'h0);
	endtask
	task automatic t_fp();
		op(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 32'h0000_0200, 2'h0);
		op(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 32'h0000_0C44, 2'h1);
		chk(rpc, 32'hABCD_4560);
		rd(ADR_SAVE_PC, 32'h0000_0C44);
		rd(ADR_EXC_SYNDROME, 32'h0000_0080);
	endtask
	task automatic t_chkstop();
		@(posedge clk);
		wchk <= 1'h1;
		@(posedge clk);
		wchk <= 1'h0;
		rd(ADR_TIMER_STATUS, {2'h0, WRS_CHKSTOP, 28'h0});
		wr(ADR_TIMER_STATUS, 32'h3000_0000);
		rd(ADR_TIMER_STATUS, 32'h0);
	endtask
	// debug, watchdog folded into the pin, system pin, power-on pin
	task automatic t_rst();
		for (int s = 0; s < 4; s++) begin
			wr(ADR_EXC_SYNDROME, 32'h0000_00A0);
			wr(ADR_MACHINE_STATE, 32'h0000_0002);
			fold <= s == 1;
			@(posedge clk);
			dbg <= s == 0;
			wrst <= s == 1;
			pin_go <= s == 2;
			por_go <= s == 3;
			iv <= s == 0;
			@(posedge clk);
			{dbg, wrst, pin_go, por_go, iv} <= 5'h0;
			wait_rst(1'h1);
			chk(commit, 1'h0);
			wait_rst(1'h0);
			if (s == 1) begin
				wait_rst(1'h1);
				wait_rst(1'h0);
			end
			chk(redir, 1'h1);
			chk(rpc, RVEC);
			rd(ADR_DEBUG_STATUS, {2'h0, LRST_SEEN, 28'h0});
			rd(ADR_EXC_SYNDROME, 32'h0);
			rd(ADR_MACHINE_STATE, MSR_RST_VAL);
			rd(ADR_TIMER_STATUS, {2'h0, s == 1 ? WRS_RSTOUT : WRS_NONE,
				28'h0});
			wr(ADR_DEBUG_STATUS, 32'h3000_0000);
			wr(ADR_TIMER_STATUS, 32'h3000_0000);
			rd(ADR_DEBUG_STATUS, 32'h0);
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		t_regs();
		t_unavail();
		t_commit();
		t_fp();
		t_chkstop();
		t_rst();
		report_and_stop();
	end
endmodule
bind reset_and_simd_exception_unit exc_unit_checker #(
	.RST_BASE_WIDE(RST_BASE_WIDE), .RSTOUT_CYCLES(RSTOUT_CYCLES)) chk_i (
	.i_core_clk, .i_rstn, .i_rst_base, .i_wdog_rst, .i_dbg_rst,
	.i_instr_valid, .i_instr_simd, .i_instr_simd_exempt, .i_fpdata_exc,
	.i_higher_pend, .o_commit, .o_suppress, .o_redirect, .o_redirect_pc,
	.o_abort, .o_rst_req_n, .o_in_reset);
